// File: rtl/vga_map_pkg.sv
// constants and types for plane mapping and set/reset block
package vga_map_pkg;
	localparam logic [15:0] SEQ_DATA_PORT    = 16'h03C5;
	localparam logic [15:0] GC_INDEX_PORT    = 16'h03CE;
	localparam logic [15:0] GC_DATA_PORT     = 16'h03CF;
	localparam logic [7:0]  SEQ_IDX_MEM_MODE = 8'h04;
	localparam logic [7:0]  SEQ_IDX_HCC_RST  = 8'h07;
	localparam logic [4:0]  GC_IDX_SET_RESET = 5'h00;
	localparam logic [4:0]  GC_IDX_LAST      = 5'h18;
	localparam int          MM_CHAIN4_BIT    = 3;
	localparam int          MM_ODD_EVEN_BIT  = 2;
	localparam int          MM_EXT_MEM_BIT   = 1;
	localparam logic [2:0]  MEM_MODE_RESET   = 3'h0;
	localparam logic [7:0]  HCC_RESET        = 8'h00;
	localparam logic [4:0]  GC_INDEX_RESET   = 5'h00;
	localparam logic [3:0]  SET_RESET_RESET  = 4'h0;
	localparam int          CPU_ADDR_W       = 18;
	localparam int          FB_ADDR_W        = 16;
	localparam logic [1:0]  WMODE_0          = 2'h0;
	localparam logic [1:0]  WMODE_3          = 2'h3;
	localparam logic [1:0]  FN_PASS          = 2'h0;
	localparam logic [1:0]  FN_AND           = 2'h1;
	localparam logic [1:0]  FN_OR            = 2'h2;
	localparam logic [1:0]  FN_XOR           = 2'h3;

	typedef struct packed {
		logic [2:0]            mem_mode;
		logic [7:0]            hcc;
		logic [4:0]            gc_index;
		logic [3:0]            set_reset;
		logic [7:0]            io_rdata;
		logic                  fb_req;
		logic                  fb_wr;
		logic                  fb_blocked;
		logic [FB_ADDR_W-1:0]  fb_addr;
		logic [3:0]            fb_plane_sel;
		logic [31:0]           fb_wdata;
		logic [31:0]           fb_wmask;
	} map_state_t;
endpackage

// File: rtl/write_path_if.sv
// carrier between the register block and the write data path
`timescale 1ns/10ps
interface write_path_if;
	logic [7:0]  cpu_data;
	logic [31:0] latch_data;
	logic [3:0]  set_reset;
	logic [3:0]  sr_enable;
	logic [1:0]  write_mode;
	logic [2:0]  rotate_count;
	logic [1:0]  func_sel;
	logic [7:0]  bit_mask;
	logic [31:0] plane_data;
	logic [31:0] plane_mask;
	modport ctrl (output cpu_data, latch_data, set_reset, sr_enable, write_mode,
		rotate_count, func_sel, bit_mask, input plane_data, plane_mask);
	modport path (input cpu_data, latch_data, set_reset, sr_enable, write_mode,
		rotate_count, func_sel, bit_mask, output plane_data, plane_mask);
endinterface

// File: rtl/vga_write_path.sv
// write data path: rotate, set/reset substitution, logic function
`timescale 1ns/10ps
module vga_write_path
	import vga_map_pkg::*;
(
	write_path_if.path wp
);
	logic [15:0] dbl;
	logic [7:0]  rot;
	logic        mode0;
	logic        mode3;

	assign dbl   = {wp.cpu_data, wp.cpu_data} >> wp.rotate_count;
	assign rot   = dbl[7:0];
	assign mode0 = (wp.write_mode == WMODE_0);
	assign mode3 = (wp.write_mode == WMODE_3);

	always_comb begin
		logic [7:0] src;
		logic [7:0] lat;
		src = 8'h00;
		lat = 8'h00;
		for (int p = 0; p < 4; p++) begin
			lat = wp.latch_data[p*8 +: 8];
			if (mode3 || (mode0 && wp.sr_enable[p]))
				src = {8{wp.set_reset[p]}};
			else
				src = rot;
			case (wp.func_sel)
				FN_AND:  wp.plane_data[p*8 +: 8] = src & lat;
				FN_OR:   wp.plane_data[p*8 +: 8] = src | lat;
				FN_XOR:  wp.plane_data[p*8 +: 8] = src ^ lat;
				default: wp.plane_data[p*8 +: 8] = src;
			endcase
			// mode 3 mask from rotated data
			wp.plane_mask[p*8 +: 8] = mode3 ? (rot & wp.bit_mask) : wp.bit_mask;
		end
	end
endmodule // vga_write_path

// File: rtl/vga_plane_map_and_set_reset.sv
// plane mapping, sequencer and graphics index registers, set/reset front end
// Function
// - reserved register bits read back zero
// - chain-four: address bits 1:0 pick plane
// - chain-four off: odd/even bit sets mapping
// - odd/even only non-paged, chain-four off
// - odd/even: address bit 0 picks plane pair
// - sequential mode: plane mask picks map
// - extended bit gates memory beyond 64KB
// - counter reset register just stores value
// - index port then data port decode
// - indexes 10, 11 via I/O only
// - five-bit graphics index, upper bits zero
// - mode 0: enabled planes take set/reset
// - mode 3: rotated data masks, set/reset colour
// - disabled planes: no set/reset substitution, except in mode 3
// - rotate write data right by count
// - function select: pass, and, or, xor
`timescale 1ns/10ps
module vga_plane_map_and_set_reset
	import vga_map_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic [15:0]           io_addr,
	input  wire logic                  io_wr,
	input  wire logic                  io_rd,
	input  wire logic [7:0]            io_wdata,
	output logic      [7:0]            io_rdata,
	input  wire logic [7:0]            sequencer_index,
	input  wire logic [3:0]            plane_write_mask,
	input  wire logic [3:0]            set_reset_enable,
	input  wire logic [1:0]            write_mode,
	input  wire logic [2:0]            rotate_count,
	input  wire logic [1:0]            func_sel,
	input  wire logic [7:0]            write_bit_mask,
	input  wire logic                  mem_req,
	input  wire logic                  mem_wr,
	input  wire logic                  mem_paged,
	input  wire logic [CPU_ADDR_W-1:0] mem_addr,
	input  wire logic [7:0]            mem_wdata,
	input  wire logic [31:0]           latch_data,
	output logic                       fb_req,
	output logic                       fb_wr,
	output logic                       fb_blocked,
	output logic      [FB_ADDR_W-1:0]  fb_addr,
	output logic      [3:0]            fb_plane_sel,
	output logic      [31:0]           fb_wdata,
	output logic      [31:0]           fb_wmask,
	output logic      [2:0]            memory_mode_bits
);
	map_state_t st_reg;
	map_state_t st_next;
	logic       seq_sel;
	logic       idx_sel;
	logic       dat_sel;
	logic       chain4;
	logic       odd_even_seq;
	logic       ext_mem;

	write_path_if wp ();

	assign wp.cpu_data     = mem_wdata;
	assign wp.latch_data   = latch_data;
	assign wp.set_reset    = st_reg.set_reset;
	assign wp.sr_enable    = set_reset_enable;
	assign wp.write_mode   = write_mode;
	assign wp.rotate_count = rotate_count;
	assign wp.func_sel     = func_sel;
	assign wp.bit_mask     = write_bit_mask;

	vga_write_path u_write_path (
		.wp (wp.path)
	);

	assign seq_sel      = (io_addr == SEQ_DATA_PORT);
	assign idx_sel      = (io_addr == GC_INDEX_PORT);
	assign dat_sel      = (io_addr == GC_DATA_PORT);
	assign chain4       = st_reg.mem_mode[MM_CHAIN4_BIT-1];
	assign odd_even_seq = st_reg.mem_mode[MM_ODD_EVEN_BIT-1];
	assign ext_mem      = st_reg.mem_mode[MM_EXT_MEM_BIT-1];

	always_comb begin
		st_next            = st_reg;
		st_next.fb_req     = 1'b0;
		st_next.fb_blocked = 1'b0;
		if (io_wr) begin
			if (seq_sel && sequencer_index == SEQ_IDX_MEM_MODE) begin
				st_next.mem_mode = io_wdata[MM_CHAIN4_BIT:MM_EXT_MEM_BIT];
			end else if (seq_sel && sequencer_index == SEQ_IDX_HCC_RST) begin
				st_next.hcc = io_wdata;
			end else if (idx_sel) begin
				st_next.gc_index = io_wdata[4:0];
			end else if (dat_sel && st_reg.gc_index == GC_IDX_SET_RESET) begin
				st_next.set_reset = io_wdata[3:0];
			end
		end
		if (io_rd) begin
			if (seq_sel && sequencer_index == SEQ_IDX_MEM_MODE) begin
				st_next.io_rdata = {4'h0, st_reg.mem_mode, 1'b0};
			end else if (seq_sel && sequencer_index == SEQ_IDX_HCC_RST) begin
				st_next.io_rdata = st_reg.hcc;
			end else if (idx_sel) begin
				st_next.io_rdata = {3'h0, st_reg.gc_index};
			end else if (dat_sel && st_reg.gc_index == GC_IDX_SET_RESET) begin
				st_next.io_rdata = {4'h0, st_reg.set_reset};
			end else begin
				st_next.io_rdata = 8'h00;
			end
		end
		if (mem_req) begin
			if (!ext_mem && mem_addr[CPU_ADDR_W-1:FB_ADDR_W] != 2'h0) begin
				st_next.fb_blocked = 1'b1;
			end else begin
				st_next.fb_req   = 1'b1;
				st_next.fb_wr    = mem_wr;
				st_next.fb_wdata = wp.plane_data;
				st_next.fb_wmask = wp.plane_mask;
				if (chain4) begin
					st_next.fb_plane_sel = 4'h1 << mem_addr[1:0];
					st_next.fb_addr      = mem_addr[FB_ADDR_W+1:2];
				end else if (!odd_even_seq && !mem_paged) begin
					st_next.fb_plane_sel = mem_addr[0] ? 4'hA : 4'h5;
					st_next.fb_addr      = mem_addr[FB_ADDR_W:1];
				end else begin
					st_next.fb_plane_sel = plane_write_mask;
					st_next.fb_addr      = mem_addr[FB_ADDR_W-1:0];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '{mem_mode: MEM_MODE_RESET, hcc: HCC_RESET, gc_index: GC_INDEX_RESET,
				set_reset: SET_RESET_RESET, io_rdata: 8'h00, fb_req: 1'b0, fb_wr: 1'b0,
				fb_blocked: 1'b0, fb_addr: 16'h0000, fb_plane_sel: 4'h0,
				fb_wdata: 32'h00000000, fb_wmask: 32'h00000000};
		end else begin
			st_reg <= st_next;
		end
	end

	assign io_rdata         = st_reg.io_rdata;
	assign fb_req           = st_reg.fb_req;
	assign fb_wr            = st_reg.fb_wr;
	assign fb_blocked       = st_reg.fb_blocked;
	assign fb_addr          = st_reg.fb_addr;
	assign fb_plane_sel     = st_reg.fb_plane_sel;
	assign fb_wdata         = st_reg.fb_wdata;
	assign fb_wmask         = st_reg.fb_wmask;
	assign memory_mode_bits = st_reg.mem_mode;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_RSVD_MM: assert property (
		$past(io_rd && seq_sel && sequencer_index == SEQ_IDX_MEM_MODE)
		|-> (io_rdata[7:4] == 4'h0 && io_rdata[0] == 1'b0))
		else $error("memory mode reserved bits not zero");
	AST_CHAIN4: assert property (
		(mem_req && chain4 && (ext_mem || mem_addr[17:16] == 2'h0))
		|=> fb_req && fb_plane_sel == (4'h1 << $past(mem_addr[1:0])))
		else $error("chain-four plane select wrong");
	AST_ODD_EVEN: assert property (
		(mem_req && !chain4 && !odd_even_seq && !mem_paged && mem_addr[17:16] == 2'h0)
		|=> fb_plane_sel == ($past(mem_addr[0]) ? 4'hA : 4'h5))
		else $error("odd/even plane pair wrong");
	AST_PAGED: assert property (
		(mem_req && !chain4 && mem_paged && mem_addr[17:16] == 2'h0)
		|=> fb_plane_sel == $past(plane_write_mask))
		else $error("paged access used odd/even mapping");
	AST_BLOCK: assert property (
		(mem_req && !ext_mem && mem_addr[17:16] != 2'h0) |=> fb_blocked && !fb_req)
		else $error("access beyond 64KB not blocked");
	AST_HCC: assert property (
		(io_wr && seq_sel && sequencer_index == SEQ_IDX_HCC_RST) ##1 io_rd && seq_sel
		&& sequencer_index == SEQ_IDX_HCC_RST && !io_wr |=> io_rdata == $past(io_wdata, 2))
		else $error("counter reset register not stored");
	AST_INDEX: assert property (
		(io_wr && idx_sel) ##1 (io_rd && idx_sel && !io_wr) |=> io_rdata == {3'h0, $past(io_wdata[4:0], 2)})
		else $error("graphics index readback wrong");
	AST_SR_DATA: assert property (
		(io_wr && dat_sel && st_reg.gc_index == GC_IDX_SET_RESET)
		|=> st_reg.set_reset == $past(io_wdata[3:0]))
		else $error("set/reset not written through data port");
	AST_MODE0: assert property (
		(mem_req && write_mode == WMODE_0 && set_reset_enable[0] && func_sel == FN_PASS
		&& (ext_mem || mem_addr[17:16] == 2'h0))
		|=> fb_wdata[7:0] == {8{$past(st_reg.set_reset[0])}})
		else $error("mode 0 set/reset not applied");
	AST_MODE3: assert property (
		(mem_req && write_mode == WMODE_3 && rotate_count == 3'h0
		&& (ext_mem || mem_addr[17:16] == 2'h0)) |=> fb_wmask[7:0] == $past(mem_wdata & write_bit_mask))
		else $error("mode 3 mask wrong");
	AST_NO_SR: assert property (
		(mem_req && write_mode == WMODE_0 && !set_reset_enable[1] && func_sel == FN_PASS
		&& rotate_count == 3'h0 && (ext_mem || mem_addr[17:16] == 2'h0))
		|=> fb_wdata[15:8] == $past(mem_wdata))
		else $error("disabled plane got substitution");
	AST_SEQ_MAP: assert property (
		(mem_req && !chain4 && odd_even_seq && (ext_mem || mem_addr[17:16] == 2'h0))
		|=> fb_req && fb_plane_sel == $past(plane_write_mask)
		&& fb_addr == $past(mem_addr[15:0]))
		else $error("sequential mapping wrong");
	AST_PASS_MODE: assert property (
		(mem_req && write_mode != WMODE_0 && write_mode != WMODE_3 && func_sel == FN_PASS
		&& rotate_count == 3'h0 && (ext_mem || mem_addr[17:16] == 2'h0))
		|=> fb_wdata == {4{$past(mem_wdata)}})
		else $error("mode 1 or 2 altered write data");
	AST_ROTATE: assert property (
		(mem_req && write_mode != WMODE_0 && write_mode != WMODE_3 && func_sel == FN_PASS
		&& rotate_count == 3'h4 && (ext_mem || mem_addr[17:16] == 2'h0))
		|=> fb_wdata[7:0] == {$past(mem_wdata[3:0]), $past(mem_wdata[7:4])})
		else $error("write data not rotated");
	AST_FUNC_XOR: assert property (
		(mem_req && write_mode == WMODE_0 && !set_reset_enable[2] && func_sel == FN_XOR
		&& rotate_count == 3'h0 && (ext_mem || mem_addr[17:16] == 2'h0))
		|=> fb_wdata[23:16] == $past(mem_wdata ^ latch_data[23:16]))
		else $error("xor with latch wrong");
	AST_IDX_RSVD: assert property (
		$past(io_rd && idx_sel) |-> io_rdata[7:5] == 3'h0)
		else $error("index reserved bits not zero");

	COV_CHAIN4: cover property (mem_req && chain4 ##1 fb_req);
	COV_BLOCK:  cover property (fb_blocked);
	COV_MODE3:  cover property (mem_req && write_mode == WMODE_3 ##1 fb_req);
	COV_ODD_EVEN: cover property (mem_req && !chain4 && !odd_even_seq && !mem_paged ##1 fb_req);
endmodule // vga_plane_map_and_set_reset

// File: verif/cpu_host.sv
// host cpu model driving the i/o port bus
`timescale 1ns/10ps
module cpu_host (
	input  wire logic        clk,
	input  wire logic [7:0]  io_rdata,
	output logic      [15:0] io_addr,
	output logic             io_wr,
	output logic             io_rd,
	output logic      [7:0]  io_wdata
);
	initial begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	// released address and data lines show inverted value, not stale data
	task automatic idle();
		io_wr <= 1'b0;
		io_rd <= 1'b0;
		io_addr <= ~io_addr;
		io_wdata <= ~io_wdata;
	endtask
	task automatic io_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge clk);
		idle();
	endtask
	// write then read back to back
	task automatic io_wr_rd(input logic [15:0] a, input logic [7:0] wd, output logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= wd;
		io_wr <= 1'b1;
		@(posedge clk);
		io_wr <= 1'b0;
		io_rd <= 1'b1;
		@(posedge clk);
		idle();
		@(negedge clk);
		d = io_rdata;
	endtask
	// single read, data taken at negedge
	task automatic io_read(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clk);
		idle();
		@(negedge clk);
		d = io_rdata;
	endtask
endmodule // cpu_host

// File: verif/test_vga_plane_map_and_set_reset.sv
// self-checking bench for plane mapping and set/reset block
`timescale 1ns/10ps
module test_vga_plane_map_and_set_reset
	import vga_map_pkg::*;
;
	logic        clk, rstn, io_wr, io_rd, mreq, mwr, mpaged, fbreq, fbwr, fbblk;
	logic [15:0] io_addr, fbaddr;
	logic [7:0]  io_wdata, io_rdata, seq_idx, bmask, wdat, rd;
	logic [3:0]  pmask, sren, fbsel, m_sr;
	logic [1:0]  wmode, fsel;
	logic [2:0]  rot, mmb, m_mode;
	logic [17:0] maddr;
	logic [31:0] latch, fbwd, fbwm, rnd;
	logic [86:0] exp_v, cm;
	int          err_total, checks_done;

	cpu_host host (.clk(clk), .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata));
	vga_plane_map_and_set_reset uut (.clk(clk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .sequencer_index(seq_idx),
		.plane_write_mask(pmask), .set_reset_enable(sren), .write_mode(wmode),
		.rotate_count(rot), .func_sel(fsel), .write_bit_mask(bmask), .mem_req(mreq),
		.mem_wr(mwr), .mem_paged(mpaged), .mem_addr(maddr), .mem_wdata(wdat),
		.latch_data(latch), .fb_req(fbreq), .fb_wr(fbwr), .fb_blocked(fbblk),
		.fb_addr(fbaddr), .fb_plane_sel(fbsel), .fb_wdata(fbwd), .fb_wmask(fbwm),
		.memory_mode_bits(mmb));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction
	task automatic miss(input string m);
		err_total++;
		$display("mismatch at %0t: %s", $time, m);
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks_done++;
		if (got !== exp)
			miss(m);
	endtask
	task automatic chk_fb(input logic [86:0] got, input logic [86:0] exp, input string m);
		checks_done++;
		if ((got & cm) !== (exp & cm))
			miss(m);
	endtask
	task automatic wr_rd(input logic [15:0] p, input logic [7:0] ix, input logic [7:0] v,
		input logic [7:0] e);
		@(posedge clk);
		seq_idx <= ix;
		host.io_wr_rd(p, v, rd);
		chk_reg(rd, e, "register readback");
	endtask
	function automatic logic [86:0] model(input logic [17:0] a, input logic w, input logic pg);
		logic [7:0]  r, b;
		logic [31:0] dat, msk;
		logic [15:0] off;
		logic [3:0]  sel;
		r = 8'({wdat, wdat} >> rot);
		for (int p = 0; p < 4; p++) begin
			b = (wmode == WMODE_3 || (wmode == WMODE_0 && sren[p])) ? {8{m_sr[p]}} : r;
			case (fsel)
				FN_AND: b = b & latch[8*p+:8];
				FN_OR: b = b | latch[8*p+:8];
				FN_XOR: b = b ^ latch[8*p+:8];
				default: b = b;
			endcase
			dat[8*p+:8] = b;
			msk[8*p+:8] = (wmode == WMODE_3) ? (r & bmask) : bmask;
		end
		if (m_mode[2]) begin
			sel = 4'h1 << a[1:0];
			off = a[17:2];
		end else if (!m_mode[1] && !pg) begin
			sel = a[0] ? 4'hA : 4'h5;
			off = a[16:1];
		end else begin
			sel = pmask;
			off = a[15:0];
		end
		if (a[17:16] != 2'h0 && !m_mode[0])
			return {2'h1, 85'h0};
		return {2'h2, w, off, sel, dat, msk};
	endfunction
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		results();
	end
	initial begin
		{rstn, mreq, mwr, mpaged, maddr, wdat, latch, seq_idx, bmask} = '0;
		{pmask, sren, wmode, rot, fsel} = '0;
		err_total = 0;
		checks_done = 0;
		rnd = 32'h8F385067;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		seq_idx <= SEQ_IDX_MEM_MODE;
		host.io_read(SEQ_DATA_PORT, rd);
		chk_reg(rd, {4'h0, MEM_MODE_RESET, 1'b0}, "memory mode after reset");
		chk_reg({5'h00, mmb}, {5'h00, MEM_MODE_RESET}, "mode bits after reset");
		wr_rd(SEQ_DATA_PORT, 8'h07, 8'h00, 8'h00);
		wr_rd(SEQ_DATA_PORT, 8'h04, 8'hFF, 8'h0E);
		chk_reg({5'h00, mmb}, 8'h07, "memory mode bits");
		wr_rd(SEQ_DATA_PORT, 8'h07, 8'hA5, 8'hA5);
		wr_rd(SEQ_DATA_PORT, 8'h04, 8'h0E, 8'h0E);
		wr_rd(GC_INDEX_PORT, 8'h00, 8'hFF, 8'h1F);
		wr_rd(GC_DATA_PORT, 8'h00, 8'h33, 8'h00);
		wr_rd(GC_INDEX_PORT, 8'h00, 8'h18, 8'h18);
		wr_rd(GC_INDEX_PORT, 8'h00, 8'h00, 8'h00);
		wr_rd(GC_DATA_PORT, 8'h00, 8'hFF, 8'h0F);
		@(posedge clk);
		seq_idx <= 8'h05;
		host.io_write(SEQ_DATA_PORT, 8'h00);
		@(posedge clk);
		seq_idx <= SEQ_IDX_MEM_MODE;
		host.io_read(SEQ_DATA_PORT, rd);
		chk_reg(rd, 8'h0E, "unmapped index write");
		$display("test registers done");
		m_mode = 3'h7;
		m_sr = 4'hF;
		for (int i = 0; i < 240; i++) begin
			rnd = lfsr(rnd);
			if (i % 16 == 0) begin
				wr_rd(SEQ_DATA_PORT, 8'h04, rnd[7:0], {4'h0, rnd[3:1], 1'b0});
				m_mode = rnd[3:1];
				wr_rd(GC_DATA_PORT, 8'h00, rnd[15:8], {4'h0, rnd[11:8]});
				m_sr = rnd[11:8];
			end
			@(posedge clk);
			{pmask, sren, wmode, rot, fsel, bmask, wdat} <=
				(i % 4 == 0) ? (rnd[30:0] & 31'h7FE3FFFF) : rnd[30:0];
			rnd = lfsr(rnd);
			latch <= rnd;
			rnd = lfsr(rnd);
			{maddr, mwr, mpaged} <= rnd[19:0];
			mreq <= 1'b1;
			@(posedge clk);
			mreq <= 1'b0;
			@(negedge clk);
			exp_v = model(maddr, mwr, mpaged);
			cm = exp_v[85] ? {2'h3, 85'h0} : mwr ? '1 : {23'h7FFFFF, 64'h0};
			chk_fb({fbreq, fbblk, fbwr, fbaddr, fbsel, fbwd, fbwm}, exp_v, "access");
		end
		$display("test mapping done");
		results();
	end
endmodule // test_vga_plane_map_and_set_reset
